// *** hdl/prg_pkg.sv ***
// prg_pkg: shared types, defaults and polynomial tables for the prbs generator
// assumes one bit clock; configuration arrives as a packed struct on plain ports
package prg_pkg;

   localparam int MAX_STAGES = 31;            // longest register
   localparam int ZLEN_W     = 8;             // width of zero-run length setting
   localparam int SHIFT_W    = 5;             // width of bit shift setting

   typedef enum logic [3:0] {
      PRG_LEN7, PRG_LEN9, PRG_LEN10, PRG_LEN11, PRG_LEN13,
      PRG_LEN15, PRG_LEN20, PRG_LEN23, PRG_LEN31
   } prg_len_e;

   typedef struct packed {
      prg_len_e             lenSel;           // pattern length selection
      logic                 polPos;           // 1: positive logic
      logic                 zsubEn;           // zero-substitution mode
      logic [ZLEN_W-1:0]    zeroLen;          // wanted zero run length
      logic [SHIFT_W-1:0]   bitShift;         // output delay in bits
   } prg_cfg_s;

   // defaults after initialisation
   localparam prg_len_e             DEF_LEN   = PRG_LEN15;
   localparam logic                 DEF_POL   = 1'b1;
   localparam logic                 DEF_ZSUB  = 1'b0;
   localparam logic [ZLEN_W-1:0]    DEF_ZLEN  = 8'h00;
   localparam logic [SHIFT_W-1:0]   DEF_SHIFT = 5'h00;
   localparam prg_cfg_s DEF_CFG = '{DEF_LEN, DEF_POL, DEF_ZSUB, DEF_ZLEN, DEF_SHIFT};

   // feedback tap masks; bit i set means stage i+1 enters the xor
   localparam logic [30:0] TAP7  = 31'h0000_0060;
   localparam logic [30:0] TAP9  = 31'h0000_0110;
   localparam logic [30:0] TAP10 = 31'h0000_0240;
   localparam logic [30:0] TAP11 = 31'h0000_0500;
   localparam logic [30:0] TAP13 = 31'h0000_1803;
   localparam logic [30:0] TAP15 = 31'h0000_6000;
   localparam logic [30:0] TAP20 = 31'h0008_0004;
   localparam logic [30:0] TAP23 = 31'h0042_0000;
   localparam logic [30:0] TAP31 = 31'h4800_0000;

   // number of stages for a selection
   function automatic logic [5:0] prgStages(prg_len_e s);
      case (s)
         PRG_LEN7:  prgStages = 6'h07;
         PRG_LEN9:  prgStages = 6'h09;
         PRG_LEN10: prgStages = 6'h0A;
         PRG_LEN11: prgStages = 6'h0B;
         PRG_LEN13: prgStages = 6'h0D;
         PRG_LEN15: prgStages = 6'h0F;
         PRG_LEN20: prgStages = 6'h14;
         PRG_LEN23: prgStages = 6'h17;
         PRG_LEN31: prgStages = 6'h1F;
         default:   prgStages = 6'h0F;
      endcase
   endfunction

   // feedback taps for a selection
   function automatic logic [30:0] prgTaps(prg_len_e s);
      case (s)
         PRG_LEN7:  prgTaps = TAP7;
         PRG_LEN9:  prgTaps = TAP9;
         PRG_LEN10: prgTaps = TAP10;
         PRG_LEN11: prgTaps = TAP11;
         PRG_LEN13: prgTaps = TAP13;
         PRG_LEN15: prgTaps = TAP15;
         PRG_LEN20: prgTaps = TAP20;
         PRG_LEN23: prgTaps = TAP23;
         PRG_LEN31: prgTaps = TAP31;
         default:   prgTaps = TAP15;
      endcase
   endfunction

   // all-ones seed over the active stages, never the lock-up state
   function automatic logic [30:0] prgSeed(prg_len_e s);
      logic [5:0] n;
      n = prgStages(s);
      prgSeed = 31'h7FFF_FFFF >> (6'd31 - n);
   endfunction

endpackage : prg_pkg

// *** hdl/prg_lfsr_step.sv ***
// prg_lfsr_step: one combinational step of the fibonacci shift register
// assumes the caller registers the state and masks nothing else
module prg_lfsr_step (
   input  wire logic [30:0]      state,     // current register, stage1 = bit0
   input  wire prg_pkg::prg_len_e lenSel,   // pattern length
   output logic [30:0]           nextState, // register after one shift
   output logic                  rawBit     // sequence bit of this position
);

   logic [5:0]  stages;
   logic [30:0] taps;
   logic [30:0] lenMask;
   logic        fb;

   // output from last stage, feedback xor of the polynomial taps
   always_comb begin
      stages    = prg_pkg::prgStages(lenSel);
      taps      = prg_pkg::prgTaps(lenSel);
      lenMask   = prg_pkg::prgSeed(lenSel);
      rawBit    = state[5'(stages - 6'd1)];
      fb        = ^(state & taps);
      nextState = {state[29:0], fb} & lenMask;
   end

endmodule // prg_lfsr_step

// *** hdl/prg_prbs_gen.sv ***
// prg_prbs_gen: bit-serial pseudo-random pattern source with zero substitution
// assumes configuration ports are synchronous to clk and loaded by cfgLoad
// Behaviour
// - N-stage register, period two^N minus one
// - one run of N ones per period
// - positive polarity: one drives low
// - taps for seven and nine stages
// - taps for ten and eleven stages
// - thirteen stages use five-term xor polynomial
// - taps for fifteen and twenty stages
// - twenty-three stages use x18 and x23
// - thirty-one stages use x28 and x31
// - force zeros after longest natural zero run
// - zero after forced run becomes one
// - longest natural zero run is N minus one
// - defaults: fifteen stages, positive, no shift
module prg_prbs_gen #(
   parameter int HIST = 32                   // depth of the bit shift delay line
) (
   input  wire logic              clk,       // bit clock
   input  wire logic              rstn,      // synchronous reset, active low
   input  wire logic              enable,    // advance the pattern
   input  wire logic              cfgLoad,   // pulse: take cfgIn and restart
   input  wire prg_pkg::prg_cfg_s cfgIn,     // new configuration
   output prg_pkg::prg_cfg_s      cfgOut,    // configuration in use
   output logic                   dataOut,   // serial pattern to the device under test
   output logic                   rawSeq,    // sequence bit before polarity, registered
   output logic                   subActive  // forced-zero segment in progress
);

   prg_pkg::prg_cfg_s  cfg_r, cfg_nxt;
   logic [30:0]        lfsr_r, lfsr_nxt;
   logic [4:0]         natCnt_r, natCnt_nxt;
   logic [prg_pkg::ZLEN_W-1:0] force_r, force_nxt;
   logic               invPend_r, invPend_nxt;
   logic [HIST-1:0]    hist_r, hist_nxt;
   logic               out_r, out_nxt;
   logic               seq_r, seq_nxt;
   logic [30:0]        stepState;
   logic               rawBit;
   logic               subBit;
   logic               shBit;
   logic [5:0]         stages;
   logic [prg_pkg::ZLEN_W-1:0] remain;

   prg_lfsr_step u_step (
      .state     (lfsr_r),
      .lenSel    (cfg_r.lenSel),
      .nextState (stepState),
      .rawBit    (rawBit)
   );

   // configuration register; defaults hold until software loads new values
   always_comb begin
      cfg_nxt = cfg_r;
      if (cfgLoad) begin
         cfg_nxt = cfgIn;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cfg_r <= prg_pkg::DEF_CFG;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // shift register and zero substitution; counters track raw zeros so the
   // substitution point is found without decoding the register state
   always_comb begin
      stages      = prg_pkg::prgStages(cfg_r.lenSel);
      remain      = cfg_r.zeroLen - prg_pkg::ZLEN_W'(stages);
      lfsr_nxt    = lfsr_r;
      natCnt_nxt  = natCnt_r;
      force_nxt   = force_r;
      invPend_nxt = invPend_r;
      subBit      = rawBit;
      if (force_r != '0) begin
         subBit      = 1'b0;
         force_nxt   = force_r - 1'b1;
         invPend_nxt = (force_r == 8'h01);
      end else if (invPend_r) begin
         subBit      = 1'b1;
         invPend_nxt = 1'b0;
      end else if (cfg_r.zsubEn && (6'(natCnt_r) == stages - 6'd1)
                   && (cfg_r.zeroLen > prg_pkg::ZLEN_W'(stages - 6'd1))) begin
         // natural run of N-1 zeros just ended; overwrite from here
         subBit      = 1'b0;
         force_nxt   = remain;
         invPend_nxt = (remain == '0);
      end
      if (enable) begin
         lfsr_nxt   = stepState;
         natCnt_nxt = rawBit ? 5'h00 : (natCnt_r == 5'h1F ? natCnt_r : natCnt_r + 5'h01);
      end else begin
         force_nxt   = force_r;
         invPend_nxt = invPend_r;
      end
      if (cfgLoad) begin
         lfsr_nxt    = prg_pkg::prgSeed(cfgIn.lenSel);
         natCnt_nxt  = 5'h00;
         force_nxt   = '0;
         invPend_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         lfsr_r    <= prg_pkg::prgSeed(prg_pkg::DEF_LEN);
         natCnt_r  <= 5'h00;
         force_r   <= '0;
         invPend_r <= 1'b0;
      end else begin
         lfsr_r    <= lfsr_nxt;
         natCnt_r  <= natCnt_nxt;
         force_r   <= force_nxt;
         invPend_r <= invPend_nxt;
      end
   end

   // bit shift delay line and output polarity; shift 0 passes straight through
   always_comb begin
      hist_nxt = hist_r;
      out_nxt  = out_r;
      seq_nxt  = seq_r;
      shBit    = (cfg_r.bitShift == '0) ? subBit : hist_r[cfg_r.bitShift - 1'b1];
      if (enable) begin
         hist_nxt = {hist_r[HIST-2:0], subBit};
         seq_nxt  = shBit;
         out_nxt  = cfg_r.polPos ? ~shBit : shBit;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         hist_r <= '0;
         out_r  <= 1'b1;
         seq_r  <= 1'b0;
      end else begin
         hist_r <= hist_nxt;
         out_r  <= out_nxt;
         seq_r  <= seq_nxt;
      end
   end

   assign cfgOut    = cfg_r;
   assign dataOut   = out_r;
   assign rawSeq    = seq_r;
   assign subActive = (force_r != '0);

endmodule // prg_prbs_gen

// *** sim/prg_prbs_gen_monitor.sv ***
// prg_prbs_gen_monitor: port assertions for the pattern generator
// assumes one bit clock and the prg_pkg config struct
module prg_prbs_gen_monitor #(
   parameter int HIST = 32  // delay depth
) (
   input wire logic              clk,       // bit clock
   input wire logic              rstn,      // reset
   input wire logic              enable,    // advance
   input wire logic              cfgLoad,   // load pulse
   input wire prg_pkg::prg_cfg_s cfgIn,     // new config
   input wire prg_pkg::prg_cfg_s cfgOut,    // config used
   input wire logic              dataOut,   // pattern
   input wire logic              rawSeq,    // bit before polarity
   input wire logic              subActive  // forcing zeros
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int NST [9] = '{7, 9, 10, 11, 13, 15, 20, 23, 31};
   logic       new_r;   // a fresh bit stands on rawSeq
   logic [8:0] ones_r;  // current run of ones
   logic [8:0] zer_r;   // current run of zeros
   int         nStg;
   assign nStg = NST[cfgOut.lenSel];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // run lengths; a load restarts the sequence, so they clear with it
   always_ff @(posedge clk) begin
      new_r <= rstn && enable && !cfgLoad;
      if (!rstn || cfgLoad) begin
         ones_r <= 9'h000;
         zer_r  <= 9'h000;
      end else if (new_r) begin
         ones_r <= rawSeq ? ones_r + 9'h001 : 9'h000;
         zer_r  <= rawSeq ? 9'h000 : zer_r + 9'h001;
      end
   end
   a_reset_state: assert property (disable iff (1'b0) !rstn |=>
      cfgOut == prg_pkg::DEF_CFG && dataOut && !rawSeq && !subActive) else $error("bad reset");
   a_first_one: assert property (new_r && ones_r == 9'h000 && zer_r == 9'h000
      && cfgOut.bitShift == 5'h00 |-> rawSeq) else $error("first bit zero");
   a_ones_run: assert property (!cfgOut.zsubEn && cfgOut.bitShift == 5'h00
      |-> ones_r <= nStg) else $error("ones run long");
   a_zero_run: assert property (cfgOut.bitShift == 5'h00 |-> zer_r <=
      ((cfgOut.zsubEn && cfgOut.zeroLen >= nStg) ? cfgOut.zeroLen : nStg - 1))
      else $error("zero run long");
   a_sub_zeros: assert property (subActive && cfgOut.bitShift == 5'h00 |-> !rawSeq)
      else $error("forced bit one");
   a_pol_map: assert property (new_r |-> dataOut == (rawSeq ^ cfgOut.polPos))
      else $error("bad polarity");
   a_cfg_keep: assert property (!cfgLoad |=> $stable(cfgOut))
      else $error("config moved");
   a_cfg_take: assert property (cfgLoad |=> cfgOut == $past(cfgIn))
      else $error("config not taken");
   a_idle_hold: assert property (!enable && !cfgLoad |=>
      $stable({dataOut, rawSeq, subActive})) else $error("idle output moved");
   c_sub: cover property (subActive);
   c_long: cover property (new_r && ones_r == 9'h01E);
   c_load: cover property (cfgLoad ##1 cfgOut.lenSel == prg_pkg::PRG_LEN31);
endmodule // prg_prbs_gen_monitor

bind prg_prbs_gen prg_prbs_gen_monitor #(.HIST(HIST)) mon_u (.clk(clk), .rstn(rstn),
   .enable(enable), .cfgLoad(cfgLoad), .cfgIn(cfgIn), .cfgOut(cfgOut),
   .dataOut(dataOut), .rawSeq(rawSeq), .subActive(subActive));

// *** sim/prg_rx_model.sv ***
// prg_rx_model: receiving device; rebuilds each bit from earlier ones
// assumes a bit stands on dIn one clock after each enabled edge
module prg_rx_model (
   input wire logic        clk,    // bit clock
   input wire logic        clr,    // restart
   input wire logic        enable, // bit strobe
   input wire logic        dIn,    // serial data
   input wire logic        pol,    // positive logic
   input wire logic [30:0] mask,   // tap stages
   input wire logic [5:0]  nStg,   // stages
   output int              nBits,  // bits seen
   output int              nErr    // breaks
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        vld_r;  // a bit stands on dIn
   logic [30:0] h_r;    // recent bits, newest at bit 0
   logic        b;
   assign b = dIn ^ pol;
   // judging waits for a full register of history, else startup counts as breaks
   always_ff @(posedge clk) begin
      vld_r <= enable && !clr;
      if (clr) begin
         nBits <= 0;
         nErr  <= 0;
      end else if (vld_r) begin
         if (nBits >= nStg && b !== ^(h_r & mask)) nErr <= nErr + 1;
         h_r   <= {h_r[29:0], b};
         nBits <= nBits + 1;
      end
   end
endmodule // prg_rx_model

// *** sim/prg_prbs_gen_bench.sv ***
// prg_prbs_gen_bench: directed scenarios for the pattern generator
// assumes prg_pkg, the generator, its monitor and the receiver model
module prg_prbs_gen_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int NST [9] = '{7, 9, 10, 11, 13, 15, 20, 23, 31};
   localparam logic [30:0] MSK [9] = '{31'h60, 31'h110, 31'h240, 31'h500, 31'h1803,
      31'h6000, 31'h80004, 31'h420000, 31'h48000000};
   logic clk = 1'b0, rstn = 1'b0, enable = 1'b0, cfgLoad = 1'b0, ePol = 1'b1;
   logic dataOut, rawSeq, subActive;
   logic q [$], qs [$];
   prg_pkg::prg_cfg_s cfgIn = prg_pkg::DEF_CFG;
   prg_pkg::prg_cfg_s cfgOut;
   int errors = 0, n_compared = 0, cyc = 0, idx = 5, nBits, nErr;
   prg_prbs_gen dut_u (.clk(clk), .rstn(rstn), .enable(enable), .cfgLoad(cfgLoad),
      .cfgIn(cfgIn), .cfgOut(cfgOut), .dataOut(dataOut), .rawSeq(rawSeq),
      .subActive(subActive));
   prg_rx_model rx_u (.clk(clk), .clr(cfgLoad), .enable(enable), .dIn(dataOut),
      .pol(ePol), .mask(MSK[idx]), .nStg(6'(NST[idx])), .nBits(nBits), .nErr(nErr));
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // load a setting, then clock n bits into q, judging dataOut on each
   task automatic run(int i, logic p, logic z, logic [7:0] zl, logic [4:0] s, int n);
      @(posedge clk) cfgLoad <= 1'b1;
      cfgIn <= '{prg_pkg::prg_len_e'(i), p, z, zl, s};
      idx <= i;
      ePol <= p;
      @(posedge clk) cfgLoad <= 1'b0;
      enable <= 1'b1;
      q.delete();
      qs.delete();
      for (int k = 0; k <= n; k++) begin
         @(posedge clk);
         if (k == n - 1) enable <= 1'b0;
         if (k > 0) q.push_back(rawSeq);
         if (k > 0) qs.push_back(subActive);
         if (k > 0) chk(dataOut, rawSeq ^ ePol);
      end
      @(posedge clk);
   endtask
   task automatic t_reset();
      chk(cfgOut, prg_pkg::DEF_CFG);
      chk({dataOut, rawSeq, subActive}, 3'h4);
      $display("t_reset end");
   endtask
   // long selections run a slice only; the full period would take too long
   task automatic t_poly();
      int n, p, w, r;
      for (int i = 0; i < 9; i++) begin
         n = NST[i];
         p = (n < 12) ? (1 << n) - 1 : 500;
         run(i, 1'b1, 1'b0, 8'h00, 5'h00, p + n);
         chk(nErr, 0);
         chk(nBits, p + n);
         w = 0;
         r = 0;
         foreach (q[k]) begin
            r = q[k] ? r + 1 : 0;
            if (r >= n && k < p + n - 1) w++;
            if (n < 12 && k >= p) chk(q[k], q[k - p]);
         end
         chk(w, 1);
      end
      $display("t_poly end");
   endtask
   task automatic t_zsub();
      int r, m, s;
      for (int j = 6; j <= 10; j += 4) begin
         run(0, 1'b1, 1'b1, 8'(j), 5'h00, 150);
         r = 0;
         m = 0;
         foreach (q[k]) begin
            r = q[k] ? 0 : r + 1;
            m = (r > m) ? r : m;
         end
         chk(m, j);
         // forced zeros past the first one, counted over one period only
         s = 0;
         for (int k = 0; k < (1 << NST[0]) - 1; k++) begin
            if (qs[k] !== 1'b0) s++;
         end
         chk(s, (j > NST[0]) ? j - NST[0] : 0);
      end
      $display("t_zsub end");
   endtask
   task automatic t_shift();
      logic q0 [$];
      run(0, 1'b0, 1'b0, 8'h00, 5'h00, 40);
      chk(nErr, 0);
      q0 = q;
      run(0, 1'b0, 1'b0, 8'h00, 5'h05, 40);
      for (int k = 5; k < 40; k++) chk(q[k], q0[k - 5]);
      $display("t_shift end");
   endtask
   task automatic finish_test();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial forever #5 clk = ~clk;
   // cut a hang short well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_poly();
      t_zsub();
      t_shift();
      finish_test();
   end
endmodule // prg_prbs_gen_bench
